// File: src/hot_swap_pkg.sv
// Constants, register map and state type for the hot swap sequencer
package hot_swap_pkg;

    // Clock and timing, times in ns
    localparam int CLK_NS       = 20;
    localparam int DIS_FILT_NS  = 1_000_000;
    localparam int VOLT_FILT_NS = 1_000_000;
    localparam int OT_FILT_NS   = 12_000;
    localparam int OC_FILT_NS   = 100_000;
    localparam int OC_REG_NS    = 3_000_000;
    localparam int RAMP_NS      = 1_000_000;
    localparam int PG_DELAY_NS  = 20_000_000;
    localparam int STARTUP_NS   = 200_000_000;

    // Least times, rounded up to whole cycles
    localparam int DIS_FILT_CYC  = (DIS_FILT_NS + CLK_NS - 1) / CLK_NS;
    localparam int VOLT_FILT_CYC = (VOLT_FILT_NS + CLK_NS - 1) / CLK_NS;
    localparam int OT_FILT_CYC   = (OT_FILT_NS + CLK_NS - 1) / CLK_NS;
    localparam int OC_FILT_CYC   = (OC_FILT_NS + CLK_NS - 1) / CLK_NS;
    localparam int OC_REG_CYC    = (OC_REG_NS + CLK_NS - 1) / CLK_NS;
    localparam int RAMP_CYC      = (RAMP_NS + CLK_NS - 1) / CLK_NS;
    localparam int PG_DELAY_CYC  = (PG_DELAY_NS + CLK_NS - 1) / CLK_NS;
    localparam int STARTUP_CYC   = (STARTUP_NS + CLK_NS - 1) / CLK_NS;

    localparam int TW        = 24;
    localparam int RETRY_W   = 4;
    localparam int MAX_RETRY = 10;
    localparam int EXT_W     = 16;

    // Filter channels
    localparam int NUM_CH = 5;
    localparam int CH_DIS = 0;
    localparam int CH_OV  = 1;
    localparam int CH_UV  = 2;
    localparam int CH_OT  = 3;
    localparam int CH_OC  = 4;

    // APB register map
    localparam int         AW            = 8;
    localparam logic [7:0] ADDR_CTRL     = 8'h00;
    localparam logic [7:0] ADDR_RAMP_EXT = 8'h04;
    localparam logic [7:0] ADDR_STATUS   = 8'h08;

    localparam int CTRL_SOFT_DIS_BIT = 0;
    localparam logic CTRL_RESET      = 1'b0;
    localparam logic [EXT_W-1:0] RAMP_EXT_RESET = 16'h0000;

    // Status field positions
    localparam int ST_STATE_LSB   = 0;
    localparam int ST_RETRY_LSB   = 4;
    localparam int ST_FLT_LSB     = 8;
    localparam int ST_GATE_BIT    = 13;
    localparam int ST_LIMOC_BIT   = 14;
    localparam int ST_REG_BIT     = 15;
    localparam int ST_PG_BIT      = 16;
    localparam int ST_OVERCURRENT_LIMIT_SET_BIT    = 17;
    localparam int ST_CHARGE_CURRENT_SET_BIT    = 18;

    typedef enum logic [3:0] {
        S_IDLE,
        S_SAMPLE,
        S_TIMER,
        S_RAMP,
        S_CHARGE,
        S_PG_DELAY,
        S_NORMAL,
        S_STOPPED
    } state_type;

endpackage : hot_swap_pkg

// File: src/filt_if.sv
// Raw level and limit in, qualified level out of one persistence filter
interface filt_if;
    import hot_swap_pkg::*;
    logic          raw;
    logic [TW-1:0] limit;
    logic          qual;
    modport filter (input raw, input limit, output qual);
    modport user   (output raw, output limit, input qual);
endinterface : filt_if

// File: src/persist_filter.sv
// Persistence filter: output follows input once it has differed for limit cycles
module persist_filter
    import hot_swap_pkg::*;
(
    input  wire logic  pclk,      // System clock
    input  wire logic  presetn,   // Async reset, active low
    input  wire logic  ce,        // Clock enable
    filt_if.filter     f          // Filter channel
);
    logic [TW-1:0] cnt_q;
    logic          qual_q;

    assign f.qual = qual_q;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            cnt_q  <= '0;
            qual_q <= 1'b0;
        end
        else if (ce)
        begin
            if (f.raw == qual_q)
                cnt_q <= '0;
            else if (cnt_q >= f.limit - 24'h000001)
            begin
                cnt_q  <= '0;
                qual_q <= f.raw;
            end
            else
                cnt_q <= cnt_q + 24'h000001;
        end
    end
endmodule : persist_filter

// File: src/hot_swap_sequencer.sv
// Start-up, gate staging and fault sequencing of a negative-rail hot swap controller
module hot_swap_sequencer
    import hot_swap_pkg::*;
#(
    parameter int DIS_FILT = DIS_FILT_CYC,   // Disable filter cycles
    parameter int VOLT_FILT = VOLT_FILT_CYC, // Voltage fault filter cycles
    parameter int OT_FILT  = OT_FILT_CYC,    // Thermal filter cycles
    parameter int OC_FILT  = OC_FILT_CYC,    // Overcurrent filter cycles
    parameter int OC_REG   = OC_REG_CYC,     // Overcurrent regulation cycles
    parameter int RAMP     = RAMP_CYC,       // Default charge ramp cycles
    parameter int PG_DELAY = PG_DELAY_CYC,   // Enhancement to power-good cycles
    parameter int STARTUP  = STARTUP_CYC     // Start-up timer cycles
)
(
    input  wire logic           pclk,                  // 50 MHz clock
    input  wire logic           presetn,               // Power-on reset, active low
    input  wire logic           ce,                    // Clock enable, freezes state
    input  wire logic           psel,                  // APB select
    input  wire logic           penable,               // APB enable
    input  wire logic           pwrite,                // APB write
    input  wire logic [AW-1:0]  paddr,                 // APB byte address
    input  wire logic [31:0]    pwdata,                // APB write data
    output logic [31:0]         prdata,                // APB read data
    output logic                pready,                // APB ready
    output logic                pslverr,               // APB error
    input  wire logic           supply_lockout_clear,  // Supply lockout released
    input  wire logic           disable_req,           // Disable pin active
    input  wire logic           ov_raw,                // Overvoltage comparator
    input  wire logic           uv_raw,                // Undervoltage comparator
    input  wire logic           ot_raw,                // Thermal shutdown comparator
    input  wire logic           oc_raw,                // Overcurrent comparator
    input  wire logic           short_raw,             // Short-circuit comparator
    input  wire logic           full_enhanced,         // Output within 0.5 V of negative rail
    input  wire logic           overcurrent_limit_set, // Overcurrent limit resistor present
    input  wire logic           charge_current_set,    // Charge limit resistor present
    output logic                gate_on,               // Gate drive enable
    output logic                ramp_active,           // Charge limit ramping from zero
    output logic                limit_is_oc,           // Active limit is overcurrent limit
    output logic                regulating,            // Current regulation at overcurrent limit
    output logic                power_good_out,        // Power good, active high
    output logic                power_good_out_n,      // Power good, active low
    output logic                overcurrent_limit_set_cfg,              // Sampled overcurrent limit config
    output logic                charge_current_set_cfg               // Sampled charge limit config
);

    ////////////////////////////////////////////////////////////////////////////////
    // Input filters

    logic [NUM_CH-1:0] raw_w;
    logic [NUM_CH-1:0] flt_w;
    logic [TW-1:0]     lim_w [NUM_CH];
    logic              soft_dis_q;

    assign raw_w = {oc_raw, ot_raw, uv_raw, ov_raw, disable_req | soft_dis_q};
    assign lim_w[CH_DIS] = TW'(DIS_FILT);
    assign lim_w[CH_OV]  = TW'(VOLT_FILT);
    assign lim_w[CH_UV]  = TW'(VOLT_FILT);
    assign lim_w[CH_OT]  = TW'(OT_FILT);
    assign lim_w[CH_OC]  = TW'(OC_FILT);

    genvar gi;
    generate
        for (gi = 0; gi < NUM_CH; gi++)
        begin : g_filt
            filt_if fi ();
            assign fi.raw   = raw_w[gi];
            assign fi.limit = lim_w[gi];
            assign flt_w[gi] = fi.qual;
            persist_filter u_filt
            (
                .pclk    (pclk),
                .presetn (presetn),
                .ce      (ce),
                .f       (fi)
            );
        end
    endgenerate

    logic dis_f;
    logic volt_bad;
    logic hard_bad;
    logic cond_ok;
    logic oc_act;

    assign dis_f    = flt_w[CH_DIS];
    assign volt_bad = flt_w[CH_OV] | flt_w[CH_UV];
    assign hard_bad = flt_w[CH_OT] | dis_f;
    assign cond_ok  = !volt_bad && !hard_bad;

    ////////////////////////////////////////////////////////////////////////////////
    // Sequencer

    state_type       state_q;
    state_type       state_d;
    logic [TW-1:0]   tmr_q;
    logic [TW-1:0]   oc_cnt_q;
    logic [RETRY_W-1:0] retry_q;
    logic            hard_bad_q;
    logic            dis_f_q;
    logic [EXT_W-1:0] ramp_ext_q;
    logic [TW-1:0]   ramp_last;
    logic            oc_expire;
    logic            retry_event;
    logic            dis_rise;

    assign ramp_last   = TW'(RAMP - 1) + TW'(ramp_ext_q);
    assign oc_act      = (state_q == S_PG_DELAY || state_q == S_NORMAL)
                         && (flt_w[CH_OC] || short_raw);
    assign oc_expire   = oc_act && (oc_cnt_q == TW'(OC_REG - 1));
    assign retry_event = (state_q == S_TIMER) && !volt_bad && hard_bad && !hard_bad_q;
    assign dis_rise    = dis_f && !dis_f_q;

    always_comb
    begin
        state_d = state_q;
        case (state_q)
            S_IDLE:
                if (supply_lockout_clear && !dis_f && !raw_w[CH_DIS])
                    state_d = S_SAMPLE;
            S_SAMPLE:
                state_d = S_TIMER;
            S_TIMER:
                if (retry_event && retry_q == RETRY_W'(MAX_RETRY))
                    state_d = S_STOPPED;
                else if (cond_ok && tmr_q == TW'(STARTUP - 1)
                         && retry_q <= RETRY_W'(MAX_RETRY))
                    state_d = S_RAMP;
            S_RAMP:
                if (!cond_ok)
                    state_d = S_TIMER;
                else if (tmr_q == ramp_last)
                    state_d = S_CHARGE;
            S_CHARGE:
                if (!cond_ok)
                    state_d = S_TIMER;
                else if (full_enhanced)
                    state_d = S_PG_DELAY;
            S_PG_DELAY:
                if (!cond_ok || oc_expire)
                    state_d = S_TIMER;
                else if (tmr_q == TW'(PG_DELAY - 1))
                    state_d = S_NORMAL;
            S_NORMAL:
                if (!cond_ok || oc_expire)
                    state_d = S_TIMER;
            S_STOPPED:
                if (dis_rise)
                    state_d = S_TIMER;
            default:
                state_d = S_IDLE;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state_q    <= S_IDLE;
            tmr_q      <= '0;
            hard_bad_q <= 1'b0;
            dis_f_q    <= 1'b0;
        end
        else if (ce)
        begin
            state_q    <= state_d;
            hard_bad_q <= hard_bad;
            dis_f_q    <= dis_f;
            // Timer restarts on any change of state and on a failed condition in S_TIMER
            if (state_d != state_q || (state_q == S_TIMER && !cond_ok))
                tmr_q <= '0;
            else
                tmr_q <= tmr_q + 24'h000001;
        end
    end

    // Overcurrent regulation timer; clearing early leaves power-good untouched
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            oc_cnt_q <= '0;
        else if (ce)
        begin
            if (oc_act && !oc_expire)
                oc_cnt_q <= oc_cnt_q + 24'h000001;
            else
                oc_cnt_q <= '0;
        end
    end

    // Retry counter
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            retry_q <= '0;
        else if (ce)
        begin
            if ((state_q == S_STOPPED && dis_rise)
                || (state_q == S_PG_DELAY && state_d == S_NORMAL))
                retry_q <= '0;
            else if (retry_event && retry_q <= RETRY_W'(MAX_RETRY))
                retry_q <= retry_q + 4'h1;
        end
    end

    // Configuration is sampled once per reset, in S_SAMPLE, after the first lockout release seen with disable inactive
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            overcurrent_limit_set_cfg <= 1'b0;
            charge_current_set_cfg <= 1'b0;
        end
        else if (ce && state_q == S_SAMPLE)
        begin
            overcurrent_limit_set_cfg <= overcurrent_limit_set;
            charge_current_set_cfg <= charge_current_set;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Gate and power-good outputs, registered from the next state

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            gate_on          <= 1'b0;
            ramp_active      <= 1'b0;
            limit_is_oc      <= 1'b0;
            regulating       <= 1'b0;
            power_good_out   <= 1'b0;
            power_good_out_n <= 1'b1;
        end
        else if (ce)
        begin
            gate_on     <= state_d == S_RAMP || state_d == S_CHARGE
                           || state_d == S_PG_DELAY || state_d == S_NORMAL;
            ramp_active <= state_d == S_RAMP;
            limit_is_oc <= state_d == S_PG_DELAY || state_d == S_NORMAL;
            regulating  <= oc_act && !oc_expire && state_d != S_TIMER;
            // Both polarities from one term so they never disagree
            power_good_out   <= state_d == S_NORMAL;
            power_good_out_n <= state_d != S_NORMAL;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // APB slave, one wait state on every access

    logic        acc;
    logic        hit;
    logic [31:0] status_w;

    assign acc = psel && penable && !pready;
    assign hit = paddr == ADDR_CTRL || paddr == ADDR_RAMP_EXT || paddr == ADDR_STATUS;

    always_comb
    begin
        status_w = '0;
        status_w[ST_STATE_LSB +: 4]       = state_q;
        status_w[ST_RETRY_LSB +: RETRY_W] = retry_q;
        status_w[ST_FLT_LSB +: NUM_CH]    = flt_w;
        status_w[ST_GATE_BIT]             = gate_on;
        status_w[ST_LIMOC_BIT]            = limit_is_oc;
        status_w[ST_REG_BIT]              = regulating;
        status_w[ST_PG_BIT]               = power_good_out;
        status_w[ST_OVERCURRENT_LIMIT_SET_BIT]             = overcurrent_limit_set_cfg;
        status_w[ST_CHARGE_CURRENT_SET_BIT]             = charge_current_set_cfg;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready     <= 1'b0;
            pslverr    <= 1'b0;
            prdata     <= '0;
            soft_dis_q <= CTRL_RESET;
            ramp_ext_q <= RAMP_EXT_RESET;
        end
        else if (ce)
        begin
            pready  <= acc;
            pslverr <= acc && !hit;
            prdata  <= '0;
            if (acc && pwrite)
            begin
                if (paddr == ADDR_CTRL)
                    soft_dis_q <= pwdata[CTRL_SOFT_DIS_BIT];
                else if (paddr == ADDR_RAMP_EXT)
                    ramp_ext_q <= pwdata[EXT_W-1:0];
            end
            else if (acc)
            begin
                case (paddr)
                    ADDR_CTRL:     prdata <= {31'h0, soft_dis_q};
                    ADDR_RAMP_EXT: prdata <= {16'h0, ramp_ext_q};
                    ADDR_STATUS:   prdata <= status_w;
                    default:       prdata <= '0;
                endcase
            end
        end
    end

endmodule : hot_swap_sequencer

// File: dv/load_model.sv
// Far-side model: load capacitor charging until the switch is fully enhanced
module load_model
#(
    parameter int ENH_DLY = 12  // Charge cycles until enhanced
)
(
    input  wire logic pclk,          // Clock
    input  wire logic presetn,       // Reset, active low
    input  wire logic gate_on,       // Gate driven
    input  wire logic ramp_active,   // Charge limit ramping
    output logic      full_enhanced  // Output near negative rail
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [15:0] chg_cnt_q;
    ////////////////////////////////////////////////////////////
    // Charge is lost at once when the gate drops, so no stale flag
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            chg_cnt_q <= 16'h0000;
        else if (!gate_on)
            chg_cnt_q <= 16'h0000;
        else if (!ramp_active && chg_cnt_q < 16'(ENH_DLY))
            chg_cnt_q <= chg_cnt_q + 16'h0001;
    end
    assign full_enhanced = (chg_cnt_q == 16'(ENH_DLY));
endmodule : load_model

// File: dv/hot_swap_chk.sv
// Port checker for the hot swap sequencer
module hot_swap_chk
#(
    parameter int DIS_FILT  = 20, // Disable filter cycles
    parameter int VOLT_FILT = 20, // Voltage filter cycles
    parameter int OC_REG    = 30, // Regulation cycles
    parameter int PG_DELAY  = 40  // Power-good delay cycles
)
(
    input wire logic pclk,             // Clock
    input wire logic presetn,          // Reset, active low
    input wire logic disable_req,      // Disable pin
    input wire logic ov_raw,           // Overvoltage
    input wire logic uv_raw,           // Undervoltage
    input wire logic ot_raw,           // Over-temperature
    input wire logic short_raw,        // Short circuit
    input wire logic full_enhanced,    // Enhanced
    input wire logic gate_on,          // Gate
    input wire logic ramp_active,      // Ramp
    input wire logic limit_is_oc,      // Limit select
    input wire logic regulating,       // Regulation
    input wire logic power_good_out,   // Power good
    input wire logic power_good_out_n  // Power good, low
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [15:0] dis_cnt_q, volt_cnt_q, reg_cnt_q, pgd_cnt_q;
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    ////////////////////////////////////////////////////////////
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            dis_cnt_q  <= 16'h0000;
            volt_cnt_q <= 16'h0000;
            reg_cnt_q  <= 16'h0000;
            pgd_cnt_q  <= 16'h0000;
        end
        else
        begin
            dis_cnt_q  <= disable_req ? dis_cnt_q + 16'h0001 : 16'h0000;
            volt_cnt_q <= (ov_raw | uv_raw) ? volt_cnt_q + 16'h0001 : 16'h0000;
            reg_cnt_q  <= regulating ? reg_cnt_q + 16'h0001 : 16'h0000;
            pgd_cnt_q  <= (limit_is_oc & ~power_good_out) ? pgd_cnt_q + 16'h0001 : 16'h0000;
        end
    end
    ////////////////////////////////////////////////////////////
    a_pg_complement: assert property (power_good_out_n == !power_good_out)
        else $error("power good pair not complementary");
    a_pg_full_on: assert property (power_good_out |-> gate_on && limit_is_oc && !ramp_active)
        else $error("power good without full turn-on");
    a_reset_off: assert property ($rose(presetn) |-> !gate_on && !power_good_out)
        else $error("outputs active after reset");
    a_ramp_gate: assert property (ramp_active |-> gate_on && !limit_is_oc)
        else $error("ramp without gate");
    a_enh_switch: assert property (gate_on && !ramp_active && !limit_is_oc && full_enhanced
        |=> limit_is_oc || !gate_on)
        else $error("limit not switched on enhancement");
    a_ot_drop: assert property (ot_raw [*8] |-> ##2 !power_good_out)
        else $error("power good kept under over-temperature");
    a_dis_drop: assert property (int'(dis_cnt_q) > DIS_FILT + 2 |-> !power_good_out)
        else $error("power good kept while disabled");
    a_volt_drop: assert property (int'(volt_cnt_q) > VOLT_FILT + 2 |-> !power_good_out)
        else $error("power good kept under voltage fault");
    a_oc_bound: assert property (int'(reg_cnt_q) <= OC_REG + 2)
        else $error("regulation lasted too long");
    a_short_fast: assert property (short_raw && power_good_out |-> ##[1:2] (regulating || !gate_on))
        else $error("short circuit not regulated");
    a_pg_delay: assert property ($rose(power_good_out)
        |-> int'(pgd_cnt_q) >= PG_DELAY - 1 && int'(pgd_cnt_q) <= PG_DELAY + 1)
        else $error("power good delay wrong");
    a_gate_fall: assert property ($fell(gate_on) |-> !power_good_out)
        else $error("power good kept with gate off");
    c_pg_up: cover property ($rose(power_good_out));
    c_regulate: cover property ($rose(regulating));
    c_oc_trip: cover property (regulating ##1 !gate_on);
endmodule : hot_swap_chk

bind hot_swap_sequencer hot_swap_chk #(.DIS_FILT(DIS_FILT), .VOLT_FILT(VOLT_FILT), .OC_REG(OC_REG),
    .PG_DELAY(PG_DELAY)) u_chk (.*);

// File: dv/tb.sv
// Self-checking bench for the hot swap sequencer
module tb
    import hot_swap_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic pclk = 1'b0, presetn = 1'b0, ce = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [AW-1:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata, rd;
    logic pready, pslverr, err, oc_raw = 1'b0, short_raw = 1'b0, supply_lockout_clear = 1'b1;
    logic overcurrent_limit_set = 1'b1, charge_current_set = 1'b0, full_enhanced;
    logic gate_on, ramp_active, limit_is_oc, regulating, power_good_out, power_good_out_n, overcurrent_limit_set_cfg, charge_current_set_cfg;
    logic [3:0] flt = 4'h0;
    wire logic disable_req, ot_raw, uv_raw, ov_raw;
    wire logic [3:0] mon;
    int mismatches = 0, check_count = 0;
    assign {disable_req, ot_raw, uv_raw, ov_raw} = flt;
    assign mon = {regulating, limit_is_oc, gate_on, power_good_out};
    always #10 pclk = ~pclk;
    hot_swap_sequencer #(.DIS_FILT(20), .VOLT_FILT(20), .OT_FILT(6), .OC_FILT(10), .OC_REG(30),
        .RAMP(8), .PG_DELAY(40), .STARTUP(100)) u_dut (.*);
    load_model #(.ENH_DLY(12)) u_load (.*);
    ////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] exp, input logic [31:0] got);
        check_count++;
        if (got !== exp)
        begin
            mismatches++;
            $display("MISMATCH t=%0t exp=%h got=%h", $time, exp, got);
        end
    endtask : chk
    task automatic apb(input logic wr, input logic [AW-1:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel   <= 1'b1;
        pwrite <= wr;
        paddr  <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // Only the watchdog ends a wait for the answer
        do
            @(posedge pclk);
        while (pready !== 1'b1);
        rd  = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic wait_for(input int i, input logic v);
        int n;
        n = 0;
        while (mon[i] !== v && n < 3000)
        begin
            @(posedge pclk);
            n++;
        end
        chk(32'(v), 32'(mon[i]));
    endtask : wait_for
    task automatic ot_pulse();
        flt <= 4'h4;
        repeat (12) @(posedge pclk);
        flt <= 4'h0;
        repeat (12) @(posedge pclk);
    endtask : ot_pulse
    ////////////////////////////////////////////////////////////
    task automatic s_regs();
        apb(1'b1, ADDR_RAMP_EXT, 32'h0000_0010);
        apb(1'b0, ADDR_RAMP_EXT, 32'h0);
        chk(32'h10, rd);
        apb(1'b0, 8'h0C, 32'h0);
        chk(32'h1, 32'(err));
        apb(1'b0, ADDR_STATUS, 32'h0);
        chk(32'h2, 32'(rd[3:0]));
    endtask : s_regs
    task automatic s_powerup();
        wait_for(1, 1'b1);
        chk(32'h2, {30'h0, ramp_active, limit_is_oc});
        chk(32'h2, {30'h0, overcurrent_limit_set_cfg, charge_current_set_cfg});
        repeat (20) @(posedge pclk);
        chk(32'h1, 32'(ramp_active));
        wait_for(2, 1'b1);
        chk(32'h0, 32'(power_good_out));
        wait_for(0, 1'b1);
        apb(1'b0, ADDR_STATUS, 32'h0);
        chk(32'h06, 32'(rd[7:0]));
    endtask : s_powerup
    task automatic s_freeze();
        // Overcurrent long enough to trip once, but every counter is frozen
        ce     <= 1'b0;
        oc_raw <= 1'b1;
        repeat (45) @(posedge pclk);
        chk(32'h5, {29'h0, gate_on, regulating, power_good_out});
        oc_raw <= 1'b0;
        ce     <= 1'b1;
        repeat (5) @(posedge pclk);
        chk(32'h5, {29'h0, gate_on, regulating, power_good_out});
    endtask : s_freeze
    task automatic s_overcurrent();
        oc_raw <= 1'b1;
        repeat (5) @(posedge pclk);
        chk(32'h1, {30'h0, regulating, power_good_out});
        repeat (10) @(posedge pclk);
        chk(32'h3, {30'h0, regulating, power_good_out});
        oc_raw <= 1'b0;
        repeat (15) @(posedge pclk);
        chk(32'h1, {30'h0, regulating, power_good_out});
        short_raw <= 1'b1;
        repeat (3) @(posedge pclk);
        chk(32'h3, {30'h0, regulating, power_good_out});
        short_raw <= 1'b0;
        repeat (5) @(posedge pclk);
        chk(32'h1, 32'(power_good_out));
        oc_raw <= 1'b1;
        repeat (25) @(posedge pclk);
        chk(32'h1, 32'(gate_on));
        wait_for(1, 1'b0);
        chk(32'h0, 32'(power_good_out));
        oc_raw <= 1'b0;
        wait_for(0, 1'b1);
    endtask : s_overcurrent
    task automatic s_faults();
        for (int i = 0; i < 4; i++)
        begin
            flt <= 4'(1 << i);
            repeat (40) @(posedge pclk);
            chk(32'h0, {30'h0, gate_on, power_good_out});
            flt <= 4'h0;
            wait_for(0, 1'b1);
        end
    endtask : s_faults
    task automatic s_retry();
        flt <= 4'h2;
        repeat (40) @(posedge pclk);
        flt <= 4'h0;
        repeat (30) @(posedge pclk);
        apb(1'b0, ADDR_STATUS, 32'h0);
        chk(32'h02, 32'(rd[7:0]));
        repeat (10) ot_pulse();
        apb(1'b0, ADDR_STATUS, 32'h0);
        chk(32'hA2, 32'(rd[7:0]));
        ot_pulse();
        repeat (150) @(posedge pclk);
        apb(1'b0, ADDR_STATUS, 32'h0);
        chk(32'h7, {28'h0, rd[3:0]} | 32'(gate_on));
        flt <= 4'h8;
        repeat (30) @(posedge pclk);
        flt <= 4'h0;
        repeat (30) @(posedge pclk);
        apb(1'b0, ADDR_STATUS, 32'h0);
        chk(32'h02, 32'(rd[7:0]));
        wait_for(0, 1'b1);
    endtask : s_retry
    task automatic s_boot_disabled();
        presetn               <= 1'b0;
        flt                   <= 4'h8;
        overcurrent_limit_set <= 1'b0;
        charge_current_set    <= 1'b1;
        repeat (2) @(posedge pclk);
        chk(32'h1, {29'h0, gate_on, power_good_out, power_good_out_n});
        presetn <= 1'b1;
        repeat (200) @(posedge pclk);
        chk(32'h1, {29'h0, gate_on, power_good_out, power_good_out_n});
        apb(1'b0, ADDR_STATUS, 32'h0);
        chk(32'h00, 32'(rd[7:0]));
        flt                  <= 4'h0;
        supply_lockout_clear <= 1'b0;
        repeat (60) @(posedge pclk);
        apb(1'b0, ADDR_STATUS, 32'h0);
        chk(32'h00, 32'(rd[7:0]));
        supply_lockout_clear <= 1'b1;
        wait_for(0, 1'b1);
        chk(32'h1, {30'h0, overcurrent_limit_set_cfg, charge_current_set_cfg});
    endtask : s_boot_disabled
    task automatic wrap_up();
        $display("Checks %0d, mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : wrap_up
    ////////////////////////////////////////////////////////////
    initial
    begin
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        s_regs();
        s_powerup();
        s_freeze();
        s_overcurrent();
        s_faults();
        s_retry();
        s_boot_disabled();
        wrap_up();
    end
    // Whole run needs about 3000 cycles
    initial
    begin
        repeat (12000) @(posedge pclk);
        mismatches++;
        wrap_up();
    end
endmodule : tb
